// ### hdl/i2c_port_pkg.sv
// shared constants for the two-wire register port and its master
package i2c_port_pkg;
  localparam logic [6:0] SLAVE_ADDR = 7'h68;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;
  localparam int BYTE_BITS = 8;
  localparam int PTR_W = 8;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam int CLK_HZ = 50_000_000;
  localparam int SCL_STD_HZ = 100_000;
  localparam int SCL_FAST_HZ = 400_000;
  // quarter-period counts of the bus clock
  localparam int QTR_STD = CLK_HZ / (4 * SCL_STD_HZ);
  localparam int QTR_FAST = CLK_HZ / (4 * SCL_FAST_HZ);
endpackage

// ### hdl/i2c_link_if.sv
// two-wire link between master and slave ends
`timescale 1ns/1ps
`default_nettype none
interface i2c_link_if;
  logic scl_m_o;
  logic scl_m_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  // open-drain wired level, pulled up
  wire logic scl;
  wire logic sda;
  assign scl = !(scl_m_oe && !scl_m_o);
  assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));
  modport slave (input scl, input sda, output sda_s_o, output sda_s_oe);
  modport master (input scl, input sda, output scl_m_o, output scl_m_oe,
    output sda_m_o, output sda_m_oe);
endinterface
`default_nettype wire

// ### hdl/i2c_sync2.sv
// two-stage synchroniser for one pin
`timescale 1ns/1ps
`default_nettype none
module i2c_sync2 (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // pin and synchronised level
  input wire logic d_i,
  output logic q_o
);
  logic meta_r;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_r <= 1'b1;
      q_o <= 1'b1;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ### hdl/i2c_slave_port.sv
// slave end: address decode, pointer, byte transfer
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - device is slave only, master drives clock
// - works at standard and fast bus rates
// - transfer begins at any start, from idle or mid-transfer
// - data fall with clock high is start
// - data rise with clock high is stop
// - data changes only while clock low
// - bytes msb first, ninth pulse acknowledges
// - acknowledge holds data low whole high phase
// - master nack ends read, slave releases
// - repeated start begins next transfer
// - first byte after start is address
// - fixed address, direction zero writes
// - direction one reads, slave drives data
// - matching address is acknowledged
// - first written byte loads register pointer
// - later written bytes stored, pointer advances
// - read starts at current pointer
// - pointer advances after each read byte
module i2c_slave_port (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // link
  i2c_link_if.slave link,
  // register file side
  output logic wr_stb_o,
  output logic [7:0] wr_addr_o,
  output logic [7:0] wr_data_o,
  output logic [7:0] rd_addr_o,
  input wire logic [7:0] rd_data_i,
  output logic busy_o
);
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_ACK, S_RX, S_TX, S_TXACK,
    S_IGNORE} state_e;
  state_e state_r;
  logic scl_s, sda_s, scl_d_r, sda_d_r;
  logic [3:0] bit_r;
  logic [7:0] sh_r, ptr_r;
  logic rd_mode_r, ptr_loaded_r, first_r, nack_r;
  logic sda_oe_r;

  i2c_sync2 u_scl (.clk_i(clk_i), .rstn_i(rstn_i), .d_i(link.scl),
    .q_o(scl_s));
  i2c_sync2 u_sda (.clk_i(clk_i), .rstn_i(rstn_i), .d_i(link.sda),
    .q_o(sda_s));

  // =====================================================
  // condition and edge decode
  wire scl_rise = scl_s && !scl_d_r;
  wire scl_fall = !scl_s && scl_d_r;
  wire start_c = scl_s && scl_d_r && sda_d_r && !sda_s;
  wire stop_c = scl_s && scl_d_r && !sda_d_r && sda_s;
  wire [7:0] rx_byte = {sh_r[6:0], sda_s};
  wire addr_hit = rx_byte[7:1] == i2c_port_pkg::SLAVE_ADDR;
  wire byte_done = bit_r == 4'(i2c_port_pkg::BYTE_BITS - 1);

  assign link.sda_s_o = 1'b0;
  assign link.sda_s_oe = sda_oe_r;

  // =====================================================
  // protocol engine, clock edges sampled on clk_i
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r <= S_IDLE;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      bit_r <= '0;
      sh_r <= '0;
      ptr_r <= i2c_port_pkg::PTR_RESET;
      rd_mode_r <= 1'b0;
      ptr_loaded_r <= 1'b0;
      first_r <= 1'b0;
      nack_r <= 1'b0;
      sda_oe_r <= 1'b0;
      wr_stb_o <= 1'b0;
      wr_addr_o <= '0;
      wr_data_o <= '0;
      rd_addr_o <= i2c_port_pkg::PTR_RESET;
      busy_o <= 1'b0;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      wr_stb_o <= 1'b0;
      rd_addr_o <= ptr_r;
      if (start_c) begin
        state_r <= S_ADDR;
        bit_r <= '0;
        sda_oe_r <= 1'b0;
        busy_o <= 1'b1;
      end else if (stop_c) begin
        state_r <= S_IDLE;
        sda_oe_r <= 1'b0;
        busy_o <= 1'b0;
      end else begin
        case (state_r)
          S_ADDR, S_RX: begin
            if (scl_rise) begin
              sh_r <= rx_byte;
              bit_r <= bit_r + 4'd1;
              if (byte_done) begin
                bit_r <= '0;
                if (state_r == S_ADDR) begin
                  if (addr_hit) begin
                    rd_mode_r <= rx_byte[0] == i2c_port_pkg::DIR_READ;
                    first_r <= rx_byte[0] == i2c_port_pkg::DIR_WRITE;
                    state_r <= S_ACK;
                  end else begin
                    state_r <= S_IGNORE;
                  end
                end else begin
                  if (first_r) begin
                    ptr_r <= rx_byte;
                    first_r <= 1'b0;
                  end else begin
                    wr_stb_o <= 1'b1;
                    wr_addr_o <= ptr_r;
                    wr_data_o <= rx_byte;
                    ptr_r <= ptr_r + 8'd1;
                  end
                  state_r <= S_ACK;
                end
              end
            end
          end
          S_ACK: begin
            // drive ack after clock falls; after ninth pulse release, or in read mode drive first data bit
            if (scl_fall) begin
              if (!sda_oe_r) begin
                sda_oe_r <= 1'b1;
              end else if (rd_mode_r) begin
                sh_r <= rd_data_i;
                sda_oe_r <= !rd_data_i[7];
                state_r <= S_TX;
              end else begin
                sda_oe_r <= 1'b0;
                state_r <= S_RX;
              end
            end
          end
          S_TX: begin
            if (scl_fall) begin
              bit_r <= bit_r + 4'd1;
              sh_r <= {sh_r[6:0], 1'b0};
              if (bit_r == 4'(i2c_port_pkg::BYTE_BITS - 1)) begin
                sda_oe_r <= 1'b0;
                bit_r <= '0;
                ptr_r <= ptr_r + 8'd1;
                state_r <= S_TXACK;
              end else begin
                sda_oe_r <= !sh_r[6];
              end
            end
          end
          S_TXACK: begin
            if (scl_rise) begin
              nack_r <= sda_s;
            end
            if (scl_fall) begin
              if (nack_r) begin
                state_r <= S_IGNORE;
              end else begin
                sh_r <= rd_data_i;
                sda_oe_r <= !rd_data_i[7];
                state_r <= S_TX;
              end
            end
          end
          S_IGNORE: sda_oe_r <= 1'b0;
          default: state_r <= S_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ### hdl/i2c_bus_master.sv
// master end: drives the bus clock, start, stop, bytes
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_master (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // command
  input wire logic fast_i,
  input wire logic start_i,
  input wire logic stop_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic ack_i,
  input wire logic [7:0] data_i,
  output logic done_o,
  output logic [7:0] data_o,
  output logic nack_o,
  output logic busy_o,
  // link
  i2c_link_if.master link
);
  typedef enum logic [2:0] {M_IDLE, M_START, M_STOP, M_BIT} mstate_e;
  mstate_e st_r;
  logic [9:0] cnt_r;
  logic [1:0] ph_r;
  logic [3:0] bit_r;
  logic [8:0] sh_r;
  logic rd_r, scl_r, sda_r;
  logic sda_s, scl_unused;
  i2c_sync2 u_sda (.clk_i(clk_i), .rstn_i(rstn_i), .d_i(link.sda),
    .q_o(sda_s));
  i2c_sync2 u_scl (.clk_i(clk_i), .rstn_i(rstn_i), .d_i(link.scl),
    .q_o(scl_unused));

  // =====================================================
  // quarter-period enable from divider
  wire [9:0] qtr = fast_i ? 10'(i2c_port_pkg::QTR_FAST)
                          : 10'(i2c_port_pkg::QTR_STD);
  wire tick = cnt_r >= qtr - 10'd1;
  assign link.scl_m_o = 1'b0;
  assign link.scl_m_oe = !scl_r;
  assign link.sda_m_o = 1'b0;
  assign link.sda_m_oe = !sda_r;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r <= M_IDLE;
      cnt_r <= '0;
      ph_r <= '0;
      bit_r <= '0;
      sh_r <= '0;
      rd_r <= 1'b0;
      scl_r <= 1'b1;
      sda_r <= 1'b1;
      done_o <= 1'b0;
      data_o <= '0;
      nack_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      cnt_r <= (st_r == M_IDLE || tick) ? 10'd0 : cnt_r + 10'd1;
      case (st_r)
        M_IDLE: begin
          ph_r <= '0;
          if (start_i) begin
            st_r <= M_START;
            busy_o <= 1'b1;
          end else if (stop_i) begin
            st_r <= M_STOP;
            busy_o <= 1'b1;
          end else if (wr_i || rd_i) begin
            st_r <= M_BIT;
            busy_o <= 1'b1;
            bit_r <= '0;
            rd_r <= rd_i;
            // read: release data, last bit is own ack
            sh_r <= rd_i ? {8'hFF, !ack_i} : {data_i, 1'b1};
          end
        end
        M_START: if (tick) begin
          // release both, then pull data while clock high
          ph_r <= ph_r + 2'd1;
          case (ph_r)
            2'd0: sda_r <= 1'b1;
            2'd1: scl_r <= 1'b1;
            2'd2: sda_r <= 1'b0;
            default: begin
              scl_r <= 1'b0;
              st_r <= M_IDLE;
              busy_o <= 1'b0;
              done_o <= 1'b1;
            end
          endcase
        end
        M_STOP: if (tick) begin
          ph_r <= ph_r + 2'd1;
          case (ph_r)
            2'd0: sda_r <= 1'b0;
            2'd1: scl_r <= 1'b1;
            2'd2: sda_r <= 1'b1;
            default: begin
              st_r <= M_IDLE;
              busy_o <= 1'b0;
              done_o <= 1'b1;
            end
          endcase
        end
        M_BIT: if (tick) begin
          ph_r <= ph_r + 2'd1;
          case (ph_r)
            2'd0: sda_r <= sh_r[8];
            2'd1: scl_r <= 1'b1;
            2'd2: begin
              sh_r <= {sh_r[7:0], 1'b1};
              if (bit_r < 4'd8) begin
                data_o <= {data_o[6:0], sda_s};
              end else begin
                nack_o <= sda_s;
              end
            end
            default: begin
              scl_r <= 1'b0;
              bit_r <= bit_r + 4'd1;
              if (bit_r == 4'd8) begin
                st_r <= M_IDLE;
                busy_o <= 1'b0;
                done_o <= 1'b1;
              end
            end
          endcase
        end
        default: st_r <= M_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ### test/i2c_link_chk.sv
// assertion checker for the two-wire link
`timescale 1ns/1ps
`default_nettype none
module i2c_link_chk (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // link lines
  input wire logic scl_m_o,
  input wire logic scl_m_oe,
  input wire logic sda_s_o,
  input wire logic sda_s_oe,
  input wire logic scl,
  input wire logic sda
);
  logic scl_r, sda_r, first_r, ign_r;
  logic [3:0] cnt_r;
  logic [7:0] sr_r;
  wire logic start_w = scl && scl_r && sda_r && !sda;
  wire logic stop_w = scl && scl_r && !sda_r && sda;
  wire logic rise_w = scl && !scl_r;
  wire logic miss_w = first_r && cnt_r == 4'h7 &&
    sr_r[6:0] != i2c_port_pkg::SLAVE_ADDR;
  wire logic [3:0] cnt_nxt = (cnt_r == 4'h8) ? 4'h0 : cnt_r + 4'h1;
  // edge history and bit count per frame
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      {scl_r, sda_r, first_r, ign_r} <= 4'h0;
      cnt_r <= 4'h0;
      sr_r <= 8'h00;
    end else begin
      {scl_r, sda_r} <= {scl, sda};
      if (start_w) begin
        {cnt_r, first_r, ign_r} <= 6'h02;
      end else if (rise_w) begin
        cnt_r <= cnt_nxt;
        sr_r <= {sr_r[6:0], sda};
        first_r <= first_r && cnt_r != 4'h8;
        ign_r <= ign_r || miss_w;
      end
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  sequence ack_low_s;
    (sda_s_oe && !sda) [*8];
  endsequence
  sequence addr_ok_s;
    rise_w && first_r && cnt_r == 4'h8 &&
      sr_r[7:1] == i2c_port_pkg::SLAVE_ADDR;
  endsequence
  drain_slave_a: assert property (sda_s_oe |-> !sda_s_o)
    else $error("slave drives data high");
  scl_drain_a: assert property (scl_m_oe |-> !scl_m_o)
    else $error("master drives clock high");
  slave_stable_a: assert property ($changed(sda_s_oe) |-> !scl)
    else $error("slave data changed with clock high");
  ack_hold_a: assert property (rise_w && sda_s_oe |-> ##1 ack_low_s)
    else $error("slave low not held in high phase");
  addr_ack_a: assert property (addr_ok_s |-> sda_s_oe && !sda)
    else $error("matching address not acknowledged");
  quiet_a: assert property (ign_r |-> !sda_s_oe)
    else $error("slave active after address mismatch");
  start_idle_a: assert property (start_w |-> $past(sda, 8) && $past(scl, 8))
    else $error("start without idle lines");
  frame_whole_a: assert property (stop_w |-> cnt_r == 4'h1)
    else $error("stop inside a byte");
endmodule
`default_nettype wire

// ### test/testbench.sv
// self-checking bench for the two-wire register port
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic fast_i = 1'b1;
  logic start_i = 1'b0, stop_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic ack_i = 1'b0, bt = 1'b0;
  logic [7:0] data_i = 8'h00;
  logic done_o, nack_o, busy_o, wr_stb_o, slv_busy;
  logic [7:0] data_o, wr_addr_o, wr_data_o, rd_addr_o, a;
  logic [7:0] mem [256];
  logic [7:0] sh [256];
  logic [8:0] e;
  logic [8:0] rq [$];
  logic [15:0] wq [$];
  int n_errors = 0, num_checks = 0, seed = 32'h1caf_c2e6;
  wire logic [7:0] rd_data_i = mem[rd_addr_o];
  wire logic [7:0] aw = {i2c_port_pkg::SLAVE_ADDR, i2c_port_pkg::DIR_WRITE};
  wire logic [7:0] ar = {i2c_port_pkg::SLAVE_ADDR, i2c_port_pkg::DIR_READ};
  always #10 clk_i = ~clk_i;
  i2c_link_if link();
  i2c_slave_port u_i2c_slave_port(.clk_i(clk_i), .rstn_i(rstn_i),
    .link(link), .wr_stb_o(wr_stb_o), .wr_addr_o(wr_addr_o),
    .wr_data_o(wr_data_o), .rd_addr_o(rd_addr_o), .rd_data_i(rd_data_i),
    .busy_o(slv_busy));
  i2c_bus_master u_i2c_bus_master(.clk_i(clk_i), .rstn_i(rstn_i),
    .fast_i(fast_i), .start_i(start_i), .stop_i(stop_i), .wr_i(wr_i),
    .rd_i(rd_i), .ack_i(ack_i), .data_i(data_i), .done_o(done_o),
    .data_o(data_o), .nack_o(nack_o), .busy_o(busy_o), .link(link));
  i2c_link_chk u_i2c_link_chk(.clk_i(clk_i), .rstn_i(rstn_i),
    .scl_m_o(link.scl_m_o), .scl_m_oe(link.scl_m_oe),
    .sda_s_o(link.sda_s_o), .sda_s_oe(link.sda_s_oe),
    .scl(link.scl), .sda(link.sda));
  // ==========================================
  // checks and commands
  task automatic chk(input string nm, input logic [15:0] x, y);
    num_checks++;
    if (x !== y) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, x, y);
    end
  endtask
  task automatic cmd(input int k, input logic [7:0] d, input logic c);
    int i;
    for (i = 0; i < 9000 && busy_o !== 1'b0; i++) @(posedge clk_i);
    if (i >= 9000) n_errors++;
    {start_i, stop_i, wr_i, rd_i} <= {k == 0, k == 1, k == 2, k == 3};
    data_i <= d;
    ack_i <= c;
    bt <= k > 1;
    @(posedge clk_i);
    {start_i, stop_i, wr_i, rd_i} <= 4'h0;
    for (i = 0; i < 9000 && done_o !== 1'b1; i++) @(posedge clk_i);
    if (i >= 9000) n_errors++;
    @(posedge clk_i);
    if (k == 0) chk("slave busy", 16'h0001, {15'h0000, slv_busy});
    if (k == 1) chk("slave busy", 16'h0000, {15'h0000, slv_busy});
  endtask
  task automatic wb(input logic [7:0] d, input logic n);
    rq.push_back({8'h00, n});
    cmd(2, d, 1'b0);
  endtask
  task automatic rb(input logic [7:0] p, input logic c);
    rq.push_back({1'b1, sh[p]});
    cmd(3, 8'h00, c);
  endtask
  task automatic put(input logic [7:0] p, input int n);
    logic [7:0] d;
    cmd(0, 8'h00, 1'b0);
    wb(aw, 1'b0);
    wb(p, 1'b0);
    repeat (n) begin
      d = $random(seed);
      wq.push_back({p, d});
      sh[p] = d;
      wb(d, 1'b0);
      p++;
    end
    cmd(1, 8'h00, 1'b0);
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ==========================================
  // result monitor
  always @(posedge clk_i) begin
    if (wr_stb_o === 1'b1) begin
      mem[wr_addr_o] <= wr_data_o;
      chk("write", wq.pop_front(), {wr_addr_o, wr_data_o});
    end
    if (done_o === 1'b1 && bt) begin
      e = rq.pop_front();
      chk("byte", e, e[8] ? {1'b1, data_o} : {8'h00, nack_o});
    end
  end
  // ==========================================
  // main sequence
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = $random(seed);
      sh[i] = mem[i];
    end
    repeat (20) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    put(8'hfe, 3);
    cmd(0, 8'h00, 1'b0);
    wb(aw, 1'b0);
    wb(8'hff, 1'b0);
    cmd(0, 8'h00, 1'b0);
    wb(ar, 1'b0);
    rb(8'hff, 1'b1);
    rb(8'h00, 1'b1);
    rb(8'h01, 1'b0);
    cmd(1, 8'h00, 1'b0);
    cmd(0, 8'h00, 1'b0);
    wb(ar, 1'b0);
    rb(8'h02, 1'b0);
    cmd(1, 8'h00, 1'b0);
    a = $random(seed);
    if (a[7:1] == i2c_port_pkg::SLAVE_ADDR) a = a ^ 8'h80;
    cmd(0, 8'h00, 1'b0);
    wb(a, 1'b1);
    cmd(1, 8'h00, 1'b0);
    fast_i <= 1'b0;
    put(8'h10, 1);
    finish_test;
  end
  initial begin
    repeat (80000) @(posedge clk_i);
    n_errors++;
    finish_test;
  end
endmodule
`default_nettype wire
